// ---- verilog/twtt_top.sv ----
// Two-wire target transmit path with address recognition
`timescale 1ns/1ps
`default_nettype none
`include "twtt_defs.svh"

// Notes on behaviour
// - 7-bit read match: ack, flag, direction one
// - Status read clears address-match flag
// - Hold clock low until first byte written
// - First byte present: release clock, shift out
// - First bit sent sets transmit-empty flag
// - Data write clears transmit-empty flag
// - No next byte at MSB: stretch clock
// - Host nack sets nack flag and interrupt
// - Transmit interrupt only while enable bit set
// - Stop or restart while addressed sets its flag
// - Status read clears stop/restart flag
// - 10-bit first byte write: ack prefix match
// - Second byte match: flag, direction zero, ack
// - Restart, read first byte: flag, direction one
// - Software addressing: byte flag, hold ack phase
module twtt_top
  import twtt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       link_clk,
  input  wire twtt_cfg_s  cfg,
  input  wire logic       data_wr,
  input  wire logic [7:0] data_wdata,
  input  wire logic       status_rd,
  input  wire logic       control_wr,
  input  wire logic       flush,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  output logic            sda_out,
  output logic            sda_oe_n,
  output var twtt_stat_s  stat
);

  // ***************************************************
  // System clock side: data register and flags
  // ***************************************************
  logic [7:0] data_reg;       // Byte waiting for the link
  logic       word_tgl_reg;   // Flips on each byte offered
  logic       ctrl_tgl_reg;   // Flips on each control write
  twtt_evt_s  evt_q;          // Link toggles after sync
  twtt_evt_s  evt_p_reg;      // Previous synced toggles
  twtt_evt_s  evt;            // One-cycle events
  twtt_evt_s  evt_l_reg;      // Link-domain toggles
  logic       addr_next;
  logic       dir_next;
  logic       empty_next;
  logic       nack_next;
  logic       stop_next;
  logic       rx_next;

  // Toggles from the link cross on two flops each
  twtt_sync #(.W(`TWTT_EVT_W)) u_evt_sync
  (
    .clk (clk),
    .d   (evt_l_reg),
    .q   (evt_q)
  );

  assign evt = evt_q ^ evt_p_reg;

  // Set wins over every clear
  assign addr_next  = evt.addr | (stat.addr_match_flag & ~status_rd);
  assign stop_next  = evt.stop | (stat.stop_restart_flag & ~status_rd);
  assign nack_next  = evt.nack | (stat.nack_seen_flag & ~status_rd);
  assign rx_next    = evt.rx | (stat.rx_full_flag & ~control_wr);
  assign empty_next = evt.taken | flush
                      | (stat.tx_empty_flag & ~data_wr);
  assign dir_next   = evt.dir_rd ? 1'b1 :
                      evt.dir_wr ? 1'b0 : stat.direction_flag;

  // Previous toggles; follows the sync in reset to avoid false events
  always_ff @(posedge clk)
  begin
    evt_p_reg <= evt_q;
  end

  // Data register, offer toggle and control toggle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      data_reg     <= 8'h00;
      word_tgl_reg <= 1'b0;
      ctrl_tgl_reg <= 1'b0;
    end
    else
    begin
      if (flush)
        word_tgl_reg <= evt_q.taken;         // Withdraw any offered byte
      else if (data_wr)
      begin
        data_reg     <= data_wdata;
        word_tgl_reg <= ~word_tgl_reg;
      end
      if (control_wr)
        ctrl_tgl_reg <= ~ctrl_tgl_reg;
    end
  end

  // Status flags and interrupt lines
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stat               <= '0;
      stat.tx_empty_flag <= `TWTT_EMPTY_RST;
    end
    else
    begin
      stat.addr_match_flag   <= addr_next;
      stat.direction_flag    <= dir_next;
      stat.tx_empty_flag     <= empty_next;
      stat.nack_seen_flag    <= nack_next;
      stat.stop_restart_flag <= stop_next;
      stat.rx_full_flag      <= rx_next;
      stat.tx_data_irq       <= empty_next & cfg.tx_irq_enable;
      stat.event_irq         <= addr_next | nack_next | stop_next | rx_next;
    end
  end

  // ***************************************************
  // Link clock side: bus engine
  // ***************************************************
  twtt_lin_s   lin_d;          // Bundle into the link domain
  twtt_lin_s   lin_q;          // Same bundle after sync
  twtt_cfg_s   lc;             // Synced configuration
  logic        rst_ln;         // Link-domain reset, active low
  logic        scl_q;
  logic        sda_q;
  logic        scl_d_reg;
  logic        sda_d_reg;
  logic        ctrl_d_reg;     // Previous synced control toggle
  twtt_state_e st_reg;
  twtt_state_e nxt_reg;        // State after the ack clock
  logic [3:0]  cnt_reg;        // Bit counter
  logic [7:0]  sh_reg;         // Received byte
  logic [7:0]  tx_sh_reg;      // Byte being sent
  logic        ten2_reg;       // Expecting second 10-bit byte
  logic        ten_seen_reg;   // Full 10-bit match since stop
  logic        first_reg;      // Current byte is first after start
  logic        busy_reg;       // Addressed since last start
  logic        nack_bit_reg;   // Sampled host answer
  logic        pin_low_reg;    // Level driven when enabled

  assign lin_d = '{resetn:   resetn,
                   ctrl_tgl: ctrl_tgl_reg,
                   word_tgl: word_tgl_reg,
                   scl:      scl_in,
                   sda:      sda_in,
                   cfg:      cfg};

  twtt_sync #(.W(`TWTT_LIN_W)) u_lin_sync
  (
    .clk (link_clk),
    .d   (lin_d),
    .q   (lin_q)
  );

  assign rst_ln = lin_q.resetn;
  assign lc     = lin_q.cfg;
  assign scl_q  = lin_q.scl;
  assign sda_q  = lin_q.sda;

  // Bus conditions
  logic scl_rise;
  logic scl_fall;
  logic start_l;
  logic stop_l;
  logic bus_evt;
  logic avail_l;
  logic ctrl_evt_l;
  assign scl_rise   = scl_q & ~scl_d_reg;
  assign scl_fall   = ~scl_q & scl_d_reg;
  assign start_l    = scl_q & scl_d_reg & sda_d_reg & ~sda_q;
  assign stop_l     = scl_q & scl_d_reg & ~sda_d_reg & sda_q;
  assign bus_evt    = start_l | stop_l | ~lc.controller_enable;
  assign avail_l    = lin_q.word_tgl ^ evt_l_reg.taken;
  assign ctrl_evt_l = lin_q.ctrl_tgl ^ ctrl_d_reg;

  // Address decode of the received byte
  logic pfx_ok;
  logic m7;
  logic gc;
  logic m10_w;
  logic m10_r;
  logic m10_2;
  logic hit;
  logic rd_hit;
  logic flag_hit;
  assign pfx_ok   = (sh_reg[7:3] == `TWTT_TEN_PREFIX)
                    && (sh_reg[2:1] == lc.own_target_address[9:8]);
  assign m7       = ~lc.ten_bit_mode
                    && (sh_reg[7:1] == lc.own_target_address[6:0]);
  assign gc       = lc.general_call_enable && (sh_reg == `TWTT_GC_ADDR);
  assign m10_w    = lc.ten_bit_mode && pfx_ok && ~sh_reg[0];
  assign m10_r    = lc.ten_bit_mode && pfx_ok && sh_reg[0]
                    && ten_seen_reg;
  assign m10_2    = sh_reg == lc.own_target_address[7:0];
  assign hit      = ten2_reg ? m10_2 : (m7 | gc | m10_w | m10_r);
  assign rd_hit   = ~ten2_reg && sh_reg[0] && (m7 | m10_r);
  assign flag_hit = ten2_reg ? m10_2 : (m7 | gc | m10_r);

  // Edge history and constant pin level
  always_ff @(posedge link_clk)
  begin
    scl_d_reg   <= scl_q;
    sda_d_reg   <= sda_q;
    ctrl_d_reg  <= lin_q.ctrl_tgl;
    pin_low_reg <= 1'b0;
  end

  assign scl_out = pin_low_reg;
  assign sda_out = pin_low_reg;

  // Bus engine
  always_ff @(posedge link_clk)
  begin
    if (!rst_ln)
    begin
      st_reg       <= ST_IDLE;
      nxt_reg      <= ST_IDLE;
      cnt_reg      <= `TWTT_CNT_ZERO;
      sh_reg       <= 8'h00;
      tx_sh_reg    <= 8'h00;
      ten2_reg     <= 1'b0;
      ten_seen_reg <= 1'b0;
      first_reg    <= 1'b0;
      busy_reg     <= 1'b0;
      nack_bit_reg <= 1'b0;
      scl_oe_n     <= 1'b1;
      sda_oe_n     <= 1'b1;
      evt_l_reg    <= '0;
    end
    else if (!lc.controller_enable)
    begin
      st_reg   <= ST_IDLE;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else if (start_l)
    begin
      // Start or repeated start: new address phase
      if (busy_reg)
        evt_l_reg.stop <= ~evt_l_reg.stop;
      st_reg    <= ST_ADDR;
      cnt_reg   <= `TWTT_CNT_ZERO;
      first_reg <= 1'b1;
      ten2_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      scl_oe_n  <= 1'b1;
      sda_oe_n  <= 1'b1;
    end
    else if (stop_l)
    begin
      if (busy_reg)
        evt_l_reg.stop <= ~evt_l_reg.stop;
      st_reg       <= ST_IDLE;
      ten_seen_reg <= 1'b0;
      busy_reg     <= 1'b0;
      scl_oe_n     <= 1'b1;
      sda_oe_n     <= 1'b1;
    end
    else
    begin
      case (st_reg)
        ST_ADDR:
        begin
          // Shift in on each rising clock
          if (scl_rise)
          begin
            sh_reg  <= {sh_reg[6:0], sda_q};
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == `TWTT_CNT_LAST)
              st_reg <= ST_ACKDEC;
          end
        end
        ST_ACKDEC:
        begin
          // Decide at the fall after the eighth bit
          if (scl_fall)
          begin
            if (lc.soft_addr_mode)
            begin
              evt_l_reg.rx <= ~evt_l_reg.rx;
              scl_oe_n     <= 1'b0;
              st_reg       <= ST_SOFTHOLD;
            end
            else if (hit)
            begin
              sda_oe_n <= 1'b0;                // Ack
              st_reg   <= ST_ACK;
              busy_reg <= 1'b1;
              if (flag_hit)
                evt_l_reg.addr <= ~evt_l_reg.addr;
              if (rd_hit)
                evt_l_reg.dir_rd <= ~evt_l_reg.dir_rd;
              else if (flag_hit)
                evt_l_reg.dir_wr <= ~evt_l_reg.dir_wr;
              if (ten2_reg)
                ten_seen_reg <= 1'b1;
              ten2_reg <= m10_w & ~ten2_reg;
              nxt_reg  <= rd_hit ? ST_TXWAIT :
                          (m10_w & ~ten2_reg) ? ST_ADDR : ST_WAIT;
            end
            else
              st_reg <= ST_WAIT;               // Not ours
          end
        end
        ST_SOFTHOLD:
        begin
          // Clock held until software writes control
          if (ctrl_evt_l)
          begin
            sda_oe_n <= lc.nack_ctrl;
            st_reg   <= ST_ACK;
            busy_reg <= 1'b1;
            if (first_reg && sh_reg[0])
              evt_l_reg.dir_rd <= ~evt_l_reg.dir_rd;
            else if (first_reg)
              evt_l_reg.dir_wr <= ~evt_l_reg.dir_wr;
            nxt_reg <= lc.nack_ctrl ? ST_WAIT :
                       (first_reg && sh_reg[0]) ? ST_TXWAIT : ST_ADDR;
          end
        end
        ST_ACK:
        begin
          // Release clock, drop ack at the end of its clock
          scl_oe_n <= 1'b1;
          if (scl_fall)
          begin
            sda_oe_n  <= 1'b1;
            st_reg    <= nxt_reg;
            cnt_reg   <= `TWTT_CNT_ZERO;
            first_reg <= 1'b0;
          end
        end
        ST_TXWAIT:
        begin
          // Stretch until a byte is offered
          if (avail_l)
          begin
            tx_sh_reg <= data_reg;
            sda_oe_n  <= data_reg[7];          // MSB first
            st_reg    <= ST_TXREL;
          end
          else
            scl_oe_n <= 1'b0;
        end
        ST_TXREL:
        begin
          scl_oe_n <= 1'b1;
          cnt_reg  <= `TWTT_CNT_ZERO;
          st_reg   <= ST_TXBIT;
        end
        ST_TXBIT:
        begin
          if (scl_rise)
          begin
            if (cnt_reg == `TWTT_CNT_ZERO)
              evt_l_reg.taken <= ~evt_l_reg.taken;
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (scl_fall)
          begin
            // Next bit only while the clock is low
            if (cnt_reg == `TWTT_CNT_BYTE)
            begin
              sda_oe_n <= 1'b1;
              st_reg   <= ST_RACK;
            end
            else
            begin
              sda_oe_n  <= tx_sh_reg[6];
              tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
          end
        end
        ST_RACK:
        begin
          // Host answer on the ninth clock
          if (scl_rise)
          begin
            nack_bit_reg <= sda_q;
            cnt_reg      <= `TWTT_CNT_ACK;
          end
          else if (scl_fall && cnt_reg == `TWTT_CNT_ACK)
          begin
            if (nack_bit_reg)
            begin
              evt_l_reg.nack <= ~evt_l_reg.nack;
              st_reg         <= ST_WAIT;
            end
            else
              st_reg <= ST_TXWAIT;
          end
        end
        ST_IDLE,
        ST_WAIT:
        begin
          // Pins released; only start, stop or controller disable leaves
          scl_oe_n <= 1'b1;
          sda_oe_n <= 1'b1;
        end
        default:
        begin
          st_reg   <= ST_IDLE;
          scl_oe_n <= 1'b1;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  sequence s_load;
    st_reg == ST_TXWAIT && avail_l && !bus_evt;
  endsequence

  sequence s_release;
    st_reg == ST_TXREL ##1 (st_reg == ST_TXBIT && scl_oe_n);
  endsequence

  a_first_release: assert property (
    @(posedge link_clk) disable iff (!rst_ln)
    s_load |=> s_release)
    else $error("clock not released after byte load");

  a_stretch_hold: assert property (
    @(posedge link_clk) disable iff (!rst_ln)
    (st_reg == ST_TXWAIT && !avail_l && !bus_evt)
    |=> (st_reg == ST_TXWAIT && !scl_oe_n))
    else $error("clock not held while no byte");

  a_sda_low_change: assert property (
    @(posedge link_clk) disable iff (!rst_ln)
    (st_reg == ST_TXBIT && $changed(sda_oe_n)) |-> !$past(scl_q))
    else $error("data changed while clock high");

  a_nack_release: assert property (
    @(posedge link_clk) disable iff (!rst_ln)
    st_reg == ST_WAIT |-> (sda_oe_n && scl_oe_n))
    else $error("pins driven while not addressed");

  a_soft_hold: assert property (
    @(posedge link_clk) disable iff (!rst_ln)
    (st_reg == ST_SOFTHOLD && !ctrl_evt_l && !bus_evt) |=> !scl_oe_n)
    else $error("ack phase not held in software mode");

  a_addr_ack: assert property (
    @(posedge link_clk) disable iff (!rst_ln)
    (st_reg == ST_ACKDEC && scl_fall && hit && !lc.soft_addr_mode
     && !bus_evt) |=> (st_reg == ST_ACK && !sda_oe_n))
    else $error("matching address not acknowledged");

  a_addr_set: assert property (
    @(posedge clk) disable iff (!resetn)
    evt.addr |=> (stat.addr_match_flag && stat.event_irq))
    else $error("address match flag or interrupt missing");

  a_addr_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    (status_rd && !evt.addr) |=> !stat.addr_match_flag)
    else $error("status read did not clear address match");

  a_stop_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    (status_rd && !evt.stop) |=> !stat.stop_restart_flag)
    else $error("status read did not clear stop flag");

  a_dir_track: assert property (
    @(posedge clk) disable iff (!resetn)
    (evt.dir_wr && !evt.dir_rd) |=> !stat.direction_flag)
    else $error("direction not cleared on write match");

  a_empty_set: assert property (
    @(posedge clk) disable iff (!resetn)
    evt.taken |=> stat.tx_empty_flag)
    else $error("first bit did not set transmit empty");

  a_empty_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    (data_wr && !evt.taken && !flush) |=> !stat.tx_empty_flag)
    else $error("data write did not clear transmit empty");

  a_txirq_gate: assert property (
    @(posedge clk) disable iff (!resetn)
    !cfg.tx_irq_enable |=> !stat.tx_data_irq)
    else $error("transmit interrupt while disabled");

  a_nack_set: assert property (
    @(posedge clk) disable iff (!resetn)
    evt.nack |=> (stat.nack_seen_flag && stat.event_irq))
    else $error("nack flag or interrupt missing");

endmodule

`default_nettype wire

// ---- verilog/twtt_defs.svh ----
// Constants shared by the two-wire target transmit block
`ifndef TWTT_DEFS_SVH
`define TWTT_DEFS_SVH

// Upper five bits of a 10-bit first address byte
`define TWTT_TEN_PREFIX  5'h1e
// General call address byte
`define TWTT_GC_ADDR     8'h00
// Bit counter values within one byte
`define TWTT_CNT_ZERO    4'h0
`define TWTT_CNT_LAST    4'h7
`define TWTT_CNT_BYTE    4'h8
`define TWTT_CNT_ACK     4'h9
// Reset value of the transmit-empty flag
`define TWTT_EMPTY_RST   1'b1
// Widths of the two crossing bundles
`define TWTT_LIN_W       21
`define TWTT_EVT_W       7

`endif

// ---- verilog/twtt_pkg.sv ----
// Types of the two-wire target transmit block
`default_nettype none

package twtt_pkg;

  // Link-side engine states
  typedef enum logic [3:0]
  {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ACKDEC   = 4'b0010,
    ST_SOFTHOLD = 4'b0011,
    ST_ACK      = 4'b0100,
    ST_TXWAIT   = 4'b0101,
    ST_TXREL    = 4'b0110,
    ST_TXBIT    = 4'b0111,
    ST_RACK     = 4'b1000,
    ST_WAIT     = 4'b1001
  } twtt_state_e;

  // Software configuration levels
  typedef struct packed
  {
    logic       controller_enable;
    logic       soft_addr_mode;
    logic       ten_bit_mode;
    logic       general_call_enable;
    logic       nack_ctrl;
    logic       tx_irq_enable;
    logic [9:0] own_target_address;
  } twtt_cfg_s;

  // Flags and interrupt lines seen by software
  typedef struct packed
  {
    logic addr_match_flag;
    logic direction_flag;
    logic tx_empty_flag;
    logic nack_seen_flag;
    logic stop_restart_flag;
    logic rx_full_flag;
    logic tx_data_irq;
    logic event_irq;
  } twtt_stat_s;

  // Event toggles from the link domain
  typedef struct packed
  {
    logic addr;
    logic dir_rd;
    logic dir_wr;
    logic rx;
    logic nack;
    logic stop;
    logic taken;
  } twtt_evt_s;

  // Everything but data_reg that the link domain samples, through its synchroniser
  typedef struct packed
  {
    logic      resetn;
    logic      ctrl_tgl;
    logic      word_tgl;
    logic      scl;
    logic      sda;
    twtt_cfg_s cfg;
  } twtt_lin_s;

endpackage

`default_nettype wire

// ---- verilog/twtt_sync.sv ----
// Two-stage synchroniser for a bundle of levels or toggles
`timescale 1ns/1ps
`default_nettype none

module twtt_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1_reg;   // Metastable stage, read by q only

  // ***************************************************
  // Two flip-flops in series
  // ***************************************************
  always_ff @(posedge clk)
  begin
    stage1_reg <= d;
    q          <= stage1_reg;
  end

endmodule

`default_nettype wire

// ---- testbench/twtt_host.sv ----
// Bus host model that addresses the target and reads from it
`timescale 1ns/1ps
`default_nettype none

module twtt_host
(
  input  wire logic lclk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe_n,
  output logic      sda_oe_n
);
  localparam int H = 6; // Half bit time in link clocks

  // Released lines float to their pull-up level
  initial
  begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end

  // Wait link clocks; falling edge keeps clear of the target's sampling
  task automatic hw(input int n);
    repeat (n) @(negedge lclk);
  endtask

  // Release the clock and wait out any stretch by the target
  task automatic rise();
    int k;
    k = 0;
    scl_oe_n = 1'b1;
    while (scl !== 1'b1 && k < 5000)
    begin
      @(negedge lclk);
      k++;
    end
    hw(H);
  endtask

  // Start or repeated start, ends with the clock low
  task automatic start();
    sda_oe_n = 1'b1;
    hw(H);
    rise();
    sda_oe_n = 1'b0;
    hw(H);
    scl_oe_n = 1'b0;
    hw(H);
  endtask

  // Stop condition, both lines released afterwards
  task automatic stop();
    sda_oe_n = 1'b0;
    hw(H);
    rise();
    sda_oe_n = 1'b1;
    hw(H);
  endtask

  // One bit: data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_oe_n = b;
    hw(H);
    rise();
    r = sda;
    scl_oe_n = 1'b0;
    hw(1);
  endtask

  // Byte out (ff = listen), then the ninth bit
  task automatic xfer(input logic [7:0] w, input logic a,
                      output logic [7:0] r, output logic ar);
    for (int i = 7; i >= 0; i--)
      bit_io(w[i], r[i]);
    bit_io(a, ar);
  endtask
endmodule

`default_nettype wire

// ---- testbench/two_wire_target_transmit_tb_top.sv ----
// Self-checking bench for the two-wire target transmit block
`timescale 1ns/1ps
`default_nettype none

module two_wire_target_transmit_tb_top;
  import twtt_pkg::*;

  logic       clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       resetn = 1'b0;
  twtt_cfg_s  cfg;
  logic       data_wr, status_rd, control_wr, flush;
  logic [7:0] data_wdata;
  logic       scl_oe_n, sda_oe_n, h_scl_n, h_sda_n;
  logic       scl_o, sda_o;     // Level the target drives when enabled
  twtt_stat_s stat;
  wire logic  scl = (scl_oe_n | scl_o) & h_scl_n; // Wired-and, pull-up
  wire logic  sda = (sda_oe_n | sda_o) & h_sda_n;
  int         err_count = 0;
  int         checked = 0;
  int         cyc = 0;
  logic [7:0] exp_q[$]; // Bytes the host should read
  logic [7:0] got, d;
  logic       ack;
  logic [9:0] own;

  always #10 clk = ~clk;
  initial
  begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  twtt_top dut (.clk(clk), .resetn(resetn), .link_clk(link_clk),
    .cfg(cfg), .data_wr(data_wr), .data_wdata(data_wdata),
    .status_rd(status_rd), .control_wr(control_wr), .flush(flush),
    .scl_in(scl), .sda_in(sda), .scl_out(scl_o), .scl_oe_n(scl_oe_n),
    .sda_out(sda_o), .sda_oe_n(sda_oe_n), .stat(stat));
  twtt_host host (.lclk(link_clk), .scl(scl), .sda(sda),
    .scl_oe_n(h_scl_n), .sda_oe_n(h_sda_n));

  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  task automatic end_sim();
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic wclk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait for one status bit
  task automatic wflag(input int b);
    int k;
    k = 0;
    while (stat[b] !== 1'b1 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
  endtask

  // Software pulses: data_wr, status_rd, control_wr, flush
  task automatic sw(input logic [3:0] m, input logic [7:0] v);
    @(negedge clk);
    {data_wr, status_rd, control_wr, flush} = m;
    data_wdata = v;
    @(negedge clk);
    {data_wr, status_rd, control_wr, flush} = 4'h0;
    wclk(3);
  endtask

  task automatic addr(input logic [7:0] b, input logic want);
    host.xfer(b, 1'b1, got, ack);
    wclk(10);
    chk(ack === want, "address ack");
  endtask

  // Two bytes out, each one stretched for lack of data
  task automatic rd_phase(input logic irq_on);
    fork
      begin
        host.xfer(8'hff, 1'b0, got, ack);
        chk(got === exp_q.pop_front(), "byte 0");
        host.xfer(8'hff, 1'b1, got, ack);
        chk(got === exp_q.pop_front(), "byte 1");
      end
      begin
        wclk(300);
        chk(scl_oe_n === 1'b0, "no first stretch");
        d = 8'($urandom);
        exp_q.push_back(d);
        sw(4'h8, d);
        chk(stat.tx_empty_flag === 1'b0, "empty kept");
        cfg.tx_irq_enable = irq_on;
        wflag(5);
        wclk(3);
        chk(stat.tx_data_irq === irq_on, "irq gate");
        wclk(2000);
        chk(scl_oe_n === 1'b0, "no msb stretch");
        d = 8'($urandom);
        exp_q.push_back(d);
        sw(4'h8, d);
      end
    join
  endtask

  // Final nack, flush, stop and status read
  task automatic fin();
    wclk(40);
    chk(stat.nack_seen_flag === 1'b1 && stat.event_irq === 1'b1,
        "nack flag");
    chk(sda_oe_n === 1'b1, "data line driven");
    cfg.tx_irq_enable = 1'b0;
    sw(4'h1, 8'h00);
    chk(stat.tx_empty_flag === 1'b1, "flush");
    host.stop();
    wclk(10);
    chk(stat.stop_restart_flag === 1'b1, "stop flag");
    sw(4'h4, 8'h00);
    chk(stat[4:3] === 2'b00, "status clear");
  endtask

  initial
  begin
    cfg = '0;
    {data_wr, status_rd, control_wr, flush} = 4'h0;
    data_wdata = 8'h00;
    void'($urandom(32'hde05ce2d));
    repeat (10) @(posedge link_clk);
    @(negedge clk) resetn = 1'b1;
    chk(stat === 8'h20 && scl_oe_n === 1'b1 && sda_oe_n === 1'b1,
        "reset");
    // 7-bit: foreign address, then a read of two bytes
    own = 10'h008 + 10'($urandom % 112);
    cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, own};
    wclk(100);
    host.start();
    addr({own[6:0] ^ 7'h01, 1'b1}, 1'b1);
    chk(stat.addr_match_flag === 1'b0, "foreign match");
    host.stop();
    host.start();
    addr({own[6:0], 1'b1}, 1'b0);
    chk(stat[7:6] === 2'b11, "read match");
    sw(4'h4, 8'h00);
    chk(stat.addr_match_flag === 1'b0, "match clear");
    rd_phase(1'b0);
    fin();
    // General call with the enable set: acked as a write match
    cfg.general_call_enable = 1'b1;
    wclk(20);
    host.start();
    addr(8'h00, 1'b0);
    chk(stat[7:6] === 2'b10, "general call match");
    host.stop();
    sw(4'h4, 8'h00);
    // 10-bit: write address, restart, read
    own = 10'($urandom);
    cfg = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, own};
    wclk(100);
    host.start();
    addr({5'h1e, own[9:8], 1'b0}, 1'b0);
    addr(own[7:0], 1'b0);
    chk(stat[7:6] === 2'b10, "ten write match");
    sw(4'h4, 8'h00);
    host.start();
    addr({5'h1e, own[9:8], 1'b1}, 1'b0);
    chk(stat[7:6] === 2'b11, "ten read match");
    sw(4'h4, 8'h00);
    rd_phase(1'b1);
    fin();
    // Software addressing: hold in ack phase until control write
    cfg = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, own};
    wclk(100);
    host.start();
    fork
      host.xfer({own[6:0], 1'b0}, 1'b1, got, ack);
      begin
        wflag(2);
        wclk(50);
        chk(scl_oe_n === 1'b0, "ack hold");
        sw(4'h2, 8'h00);
        chk(stat.rx_full_flag === 1'b0, "rx clear");
      end
    join
    chk(ack === 1'b1, "soft ack value");
    host.stop();
    wclk(20);
    end_sim();
  end
endmodule

`default_nettype wire
